// ### core/risc_core_defines.vh
// Constants for the 14-bit instruction decode and execute core.
// Assumes a 7-bit file address space, a 13-bit program counter and a 32-bit AXI4-Lite bus.
// Operation
// - Flags from an instruction override status writes; clearing status leaves 00000100.
// - Pin direction bit 3 always reads one, also inside read-modify-write.
// - Any counter low byte write loads it and copies the latch into the high byte.
// - Bit set and clear read, modify and write back the whole register; bit tests only read it.
// - One cycle normally; branch, return, counter low byte write or true skip takes two, second a no-op.
// - A port modified as a function of itself reads the pin levels.
// - Writing timer zero clears the prescaler when it belongs to timer zero.
// - Byte ops: bits 13:12 are 00, opcode 11:8, destination 7, address 6:0.
// - Byte opcodes and flags: add, and, sub, or, xor, com, dec, inc, move, swap.
// - 0001 clears file or working register; 0000 moves to file or is no-op.
// - 1011 decrements, 1111 increments, skip when zero, no flags changed.
// - 1101 rotates left, 1100 rotates right through carry; only carry updated.
// - Bit ops: prefix 01, op 11:10, index 9:7; clear, set, skip clear, skip set.
// - Prefix 10: bit 11 clear calls and pushes, set jumps; 11-bit target, two cycles.
// - Literal ops: prefix 11, add, subtract, and, or, xor, load into working register.
// - Literal code 01xx loads the literal and returns from subroutine in two cycles.
// - 0x063 enters standby, 0x064 clears watchdog; both update timeout and power-down.
// - Destination zero writes the working register, one writes the file register.
// - Each instruction cycle spans four oscillator periods.
// - The 7-bit file address selects a register from 0x00 to 0x7f.
`ifndef RISC_CORE_DEFINES_VH
`define RISC_CORE_DEFINES_VH

`define CYCLE_PHASES 2'h3
`define ADDR_TIMER 7'h01
`define ADDR_PC_LO 7'h02
`define ADDR_STATUS 7'h03
`define ADDR_PORT 7'h05
`define ADDR_DIR 7'h06
`define ADDR_PC_HOLD 7'h0a
`define ADDR_INTCON 7'h0b
`define ADDR_MAX 7'h7f

`define BIT_C 0
`define BIT_DIGIT 1
`define BIT_Z 2
`define BIT_PWRDN 3
`define BIT_TIMEOUT 4
`define BIT_INT_EN 7
`define DIR_FORCED 8'h08

`define RST_STATUS 8'h18
`define RST_DIR 8'hff
`define RST_PC_HOLD 5'h00
`define RST_PC 13'h0000

`define BYTE_NOPMOV 4'h0
`define BYTE_CLR 4'h1
`define BYTE_SUB 4'h2
`define BYTE_DEC 4'h3
`define BYTE_OR 4'h4
`define BYTE_AND 4'h5
`define BYTE_XOR 4'h6
`define BYTE_ADD 4'h7
`define BYTE_MOV 4'h8
`define BYTE_COM 4'h9
`define BYTE_INC 4'ha
`define BYTE_DECSZ 4'hb
`define BYTE_RR 4'hc
`define BYTE_RL 4'hd
`define BYTE_SWAP 4'he
`define BYTE_INCSZ 4'hf
`define CTRL_RET 8'h08
`define CTRL_INT_RET 8'h09
`define CTRL_SLEEP 8'h63
`define CTRL_WD_CLEAR 8'h64
`define CTRL_W_CLEAR 8'h03
`define LIT_ADD 4'b111?
`define LIT_SUB 4'b110?
`define LIT_AND 4'b1001
`define LIT_OR 4'b1000
`define LIT_XOR 4'b1010
`define LIT_LOAD 4'b00??
`define LIT_RET 4'b01??

`define ALU_ADD 4'h0
`define ALU_SUB 4'h1
`define ALU_AND 4'h2
`define ALU_OR 4'h3
`define ALU_XOR 4'h4
`define ALU_COM 4'h5
`define ALU_DEC 4'h6
`define ALU_INC 4'h7
`define ALU_PASSA 4'h8
`define ALU_SWAP 4'h9
`define ALU_RL 4'ha
`define ALU_RR 4'hb
`define ALU_CLR 4'hc
`define ALU_PASSW 4'hd
`define ALU_BCLR 4'he
`define ALU_BSET 4'hf

`define AXI_CTRL 8'h00
`define AXI_STATE 8'h04
`define AXI_CORE 8'h08
`define AXI_INSTR 8'h0c
`define RST_RUN 1'b1
`define RESP_OKAY 2'b00
`define RESP_SLVERR 2'b10

`endif

// ### core/byte_alu.v
// Eight-bit arithmetic and logic unit of the instruction core.
// Purely combinational; the caller picks which flags to keep.
`timescale 1ns/1ns
`default_nettype none
`include "risc_core_defines.vh"

module byte_alu (
	input wire [3:0] alu_op, // Operation select
	input wire [7:0] opnd_a, // File or literal operand
	input wire [7:0] opnd_w, // Working register
	input wire [2:0] bit_sel, // Bit index for bit ops
	input wire carry_in, // Current carry flag
	output reg [7:0] result, // Operation result
	output reg carry_out, // New carry
	output reg digit_carry_out, // New digit carry
	output wire zero_out // Result is zero
);
	reg [8:0] sum9;
	reg [4:0] low5;
	wire [7:0] mask;

	assign mask = 8'h01 << bit_sel;
	assign zero_out = (result == 8'h00);

	always @* begin
		sum9 = 9'h000;
		low5 = 5'h00;
		result = opnd_a;
		carry_out = carry_in;
		digit_carry_out = 1'b0;
		case (alu_op)
		`ALU_ADD: begin
			sum9 = {1'b0, opnd_a} + {1'b0, opnd_w};
			low5 = {1'b0, opnd_a[3:0]} + {1'b0, opnd_w[3:0]};
			result = sum9[7:0];
			carry_out = sum9[8];
			digit_carry_out = low5[4];
		end
		`ALU_SUB: begin
			// Carry set means no borrow
			sum9 = {1'b0, opnd_a} + {1'b0, ~opnd_w} + 9'h001;
			low5 = {1'b0, opnd_a[3:0]} + {1'b0, ~opnd_w[3:0]} + 5'h01;
			result = sum9[7:0];
			carry_out = sum9[8];
			digit_carry_out = low5[4];
		end
		`ALU_AND: result = opnd_a & opnd_w;
		`ALU_OR: result = opnd_a | opnd_w;
		`ALU_XOR: result = opnd_a ^ opnd_w;
		`ALU_COM: result = ~opnd_a;
		`ALU_DEC: result = opnd_a - 8'h01;
		`ALU_INC: result = opnd_a + 8'h01;
		`ALU_SWAP: result = {opnd_a[3:0], opnd_a[7:4]};
		`ALU_RL: begin
			result = {opnd_a[6:0], carry_in};
			carry_out = opnd_a[7];
		end
		`ALU_RR: begin
			result = {carry_in, opnd_a[7:1]};
			carry_out = opnd_a[0];
		end
		`ALU_CLR: result = 8'h00;
		`ALU_PASSW: result = opnd_w;
		`ALU_BCLR: result = opnd_a & ~mask;
		`ALU_BSET: result = opnd_a | mask;
		default: result = opnd_a;
		endcase
	end
endmodule
`default_nettype wire

// ### core/risc_14bit_instruction_decode.v
// Instruction decode and execute core with special function registers.
// Program memory and external file registers answer within one clock of their address.
`timescale 1ns/1ns
`default_nettype none
`include "risc_core_defines.vh"

module risc_14bit_instruction_decode #(
	parameter PC_W = 13,
	parameter STACK_DEPTH = 8,
	parameter SP_W = 3
) (
	input wire clock, // 125 MHz oscillator clock
	input wire rst_b, // Asynchronous reset, active low
	input wire [7:0] s_axi_awaddr, // AXI write address
	input wire s_axi_awvalid, // AXI write address valid
	output wire s_axi_awready, // AXI write address ready
	input wire [31:0] s_axi_wdata, // AXI write data
	input wire [3:0] s_axi_wstrb, // AXI write strobes
	input wire s_axi_wvalid, // AXI write data valid
	output wire s_axi_wready, // AXI write data ready
	output reg [1:0] s_axi_bresp, // AXI write response
	output reg s_axi_bvalid, // AXI write response valid
	input wire s_axi_bready, // AXI write response ready
	input wire [7:0] s_axi_araddr, // AXI read address
	input wire s_axi_arvalid, // AXI read address valid
	output wire s_axi_arready, // AXI read address ready
	output reg [31:0] s_axi_rdata, // AXI read data
	output reg [1:0] s_axi_rresp, // AXI read response
	output reg s_axi_rvalid, // AXI read data valid
	input wire s_axi_rready, // AXI read data ready
	output reg [PC_W-1:0] prog_addr, // Program memory address
	input wire [13:0] instr_data, // Instruction word
	output wire [6:0] file_addr, // External file read address
	input wire [7:0] file_rdata, // External file read data
	output reg [6:0] file_waddr, // External file write address
	output reg [7:0] file_wdata, // External file write data
	output reg file_we, // External file write pulse
	input wire [7:0] pins_in, // Port pin levels, asynchronous
	output reg [7:0] port_out, // Port output latch
	output reg [7:0] pin_dir, // Pin direction register, 1 = input
	input wire prescaler_to_timer, // Prescaler assigned to timer zero
	output reg prescaler_clear, // Prescaler clear pulse
	output reg watchdog_clear, // Watchdog clear pulse
	output reg standby, // Core in standby
	input wire wake, // Wake from standby, same clock
	output reg global_interrupt_enable // Global interrupt enable bit
);
	reg [1:0] phase_reg;
	reg [13:0] ir_reg;
	reg [7:0] fdata_reg;
	reg flush_reg;
	reg [7:0] wreg_reg;
	reg [7:0] status_reg;
	reg [4:0] pc_hold_reg;
	reg [SP_W-1:0] sp_reg;
	reg [PC_W-1:0] stack_mem [0:STACK_DEPTH-1];
	reg run_reg;
	reg [7:0] sync1_reg, sync2_reg, sync3_reg, pins_reg;
	reg aw_held_reg, w_held_reg;
	reg [7:0] awaddr_reg;
	reg [31:0] wdata_reg;
	reg [3:0] wstrb_reg;

	reg [3:0] alu_op;
	reg use_lit, wr_w, wr_f, upd_c, upd_dc, upd_z;
	reg skip_zero, bit_test, test_set, do_branch, do_call, do_ret;
	reg do_int_ret, do_sleep, do_wd_clear;
	reg [7:0] opnd_a;
	reg [7:0] status_next;
	reg [PC_W-1:0] pc_next;
	reg take_two;
	wire [7:0] alu_result;
	wire alu_c, alu_dc, alu_z;
	wire [6:0] faddr;
	wire [7:0] lit;
	wire [7:0] file_val;
	wire running, commit, skip_hit;
	wire [PC_W-1:0] pc_inc, ret_addr;

	function is_internal;
		input [6:0] a;
		begin
			is_internal = (a == `ADDR_PC_LO) || (a == `ADDR_STATUS) || (a == `ADDR_PORT) ||
				(a == `ADDR_DIR) || (a == `ADDR_PC_HOLD) || (a == `ADDR_INTCON);
		end
	endfunction

	function [7:0] read_file;
		input [6:0] a;
		begin
			case (a)
			`ADDR_PC_LO: read_file = prog_addr[7:0];
			`ADDR_STATUS: read_file = status_reg;
			`ADDR_PORT: read_file = pins_reg;
			`ADDR_DIR: read_file = pin_dir | `DIR_FORCED;
			`ADDR_PC_HOLD: read_file = {3'h0, pc_hold_reg};
			`ADDR_INTCON: read_file = {global_interrupt_enable, 7'h00};
			default: read_file = fdata_reg;
			endcase
		end
	endfunction

	assign faddr = ir_reg[6:0] & `ADDR_MAX;
	assign file_addr = faddr;
	assign lit = ir_reg[7:0];
	assign file_val = read_file(faddr);
	assign running = run_reg & ~standby;
	assign commit = running && (phase_reg == `CYCLE_PHASES);
	assign pc_inc = prog_addr + {{(PC_W-1){1'b0}}, 1'b1};
	assign ret_addr = stack_mem[sp_reg - {{(SP_W-1){1'b0}}, 1'b1}];
	assign skip_hit = (skip_zero & alu_z) | (bit_test & (opnd_a[ir_reg[9:7]] == test_set));

	byte_alu u_alu (
		.alu_op(alu_op),
		.opnd_a(opnd_a),
		.opnd_w(wreg_reg),
		.bit_sel(ir_reg[9:7]),
		.carry_in(status_reg[`BIT_C]),
		.result(alu_result),
		.carry_out(alu_c),
		.digit_carry_out(alu_dc),
		.zero_out(alu_z)
	);

	// Decode of the held instruction word
	always @* begin
		alu_op = `ALU_PASSA;
		use_lit = 1'b0;
		wr_w = 1'b0;
		wr_f = 1'b0;
		upd_c = 1'b0;
		upd_dc = 1'b0;
		upd_z = 1'b0;
		skip_zero = 1'b0;
		bit_test = 1'b0;
		test_set = 1'b0;
		do_branch = 1'b0;
		do_call = 1'b0;
		do_ret = 1'b0;
		do_int_ret = 1'b0;
		do_sleep = 1'b0;
		do_wd_clear = 1'b0;
		case (ir_reg[13:12])
		2'b00: begin
			wr_w = ~ir_reg[7];
			wr_f = ir_reg[7];
			case (ir_reg[11:8])
			`BYTE_ADD: begin
				alu_op = `ALU_ADD;
				{upd_c, upd_dc, upd_z} = 3'h7;
			end
			`BYTE_SUB: begin
				alu_op = `ALU_SUB;
				{upd_c, upd_dc, upd_z} = 3'h7;
			end
			`BYTE_AND: begin
				alu_op = `ALU_AND;
				upd_z = 1'b1;
			end
			`BYTE_OR: begin
				alu_op = `ALU_OR;
				upd_z = 1'b1;
			end
			`BYTE_XOR: begin
				alu_op = `ALU_XOR;
				upd_z = 1'b1;
			end
			`BYTE_COM: begin
				alu_op = `ALU_COM;
				upd_z = 1'b1;
			end
			`BYTE_DEC: begin
				alu_op = `ALU_DEC;
				upd_z = 1'b1;
			end
			`BYTE_INC: begin
				alu_op = `ALU_INC;
				upd_z = 1'b1;
			end
			`BYTE_MOV: upd_z = 1'b1;
			`BYTE_SWAP: alu_op = `ALU_SWAP;
			`BYTE_DECSZ: begin
				alu_op = `ALU_DEC;
				skip_zero = 1'b1;
			end
			`BYTE_INCSZ: begin
				alu_op = `ALU_INC;
				skip_zero = 1'b1;
			end
			`BYTE_RL: begin
				alu_op = `ALU_RL;
				upd_c = 1'b1;
			end
			`BYTE_RR: begin
				alu_op = `ALU_RR;
				upd_c = 1'b1;
			end
			`BYTE_CLR: begin
				alu_op = `ALU_CLR;
				wr_w = (ir_reg[7:0] == `CTRL_W_CLEAR);
				upd_z = ir_reg[7] | (ir_reg[7:0] == `CTRL_W_CLEAR);
			end
			default: begin
				wr_w = 1'b0;
				alu_op = `ALU_PASSW;
				do_ret = (ir_reg[7:0] == `CTRL_RET) || (ir_reg[7:0] == `CTRL_INT_RET);
				do_int_ret = (ir_reg[7:0] == `CTRL_INT_RET);
				do_sleep = (ir_reg[7:0] == `CTRL_SLEEP);
				do_wd_clear = (ir_reg[7:0] == `CTRL_WD_CLEAR);
			end
			endcase
		end
		2'b01: begin
			case (ir_reg[11:10])
			2'b00: begin
				alu_op = `ALU_BCLR;
				wr_f = 1'b1;
			end
			2'b01: begin
				alu_op = `ALU_BSET;
				wr_f = 1'b1;
			end
			2'b10: bit_test = 1'b1;
			default: begin
				bit_test = 1'b1;
				test_set = 1'b1;
			end
			endcase
		end
		2'b10: begin
			do_branch = 1'b1;
			do_call = ~ir_reg[11];
		end
		default: begin
			use_lit = 1'b1;
			wr_w = 1'b1;
			casez (ir_reg[11:8])
			`LIT_ADD: begin
				alu_op = `ALU_ADD;
				{upd_c, upd_dc, upd_z} = 3'h7;
			end
			`LIT_SUB: begin
				alu_op = `ALU_SUB;
				{upd_c, upd_dc, upd_z} = 3'h7;
			end
			`LIT_AND: begin
				alu_op = `ALU_AND;
				upd_z = 1'b1;
			end
			`LIT_OR: begin
				alu_op = `ALU_OR;
				upd_z = 1'b1;
			end
			`LIT_XOR: begin
				alu_op = `ALU_XOR;
				upd_z = 1'b1;
			end
			`LIT_LOAD: alu_op = `ALU_PASSA;
			`LIT_RET: do_ret = 1'b1;
			default: wr_w = 1'b0;
			endcase
		end
		endcase
	end

	// Operand, flags and next counter for the committing instruction
	always @* begin
		opnd_a = use_lit ? lit : file_val;
		status_next = status_reg;
		if (wr_f && (faddr == `ADDR_STATUS))
			status_next = alu_result;
		if (upd_c)
			status_next[`BIT_C] = alu_c;
		if (upd_dc)
			status_next[`BIT_DIGIT] = alu_dc;
		if (upd_z)
			status_next[`BIT_Z] = alu_z;
		if (do_sleep) begin
			status_next[`BIT_TIMEOUT] = 1'b1;
			status_next[`BIT_PWRDN] = 1'b0;
		end
		if (do_wd_clear) begin
			status_next[`BIT_TIMEOUT] = 1'b1;
			status_next[`BIT_PWRDN] = 1'b1;
		end
		take_two = 1'b1;
		if (do_branch)
			pc_next = {pc_hold_reg[4:3], ir_reg[10:0]};
		else if (do_ret)
			pc_next = ret_addr;
		else if (wr_f && (faddr == `ADDR_PC_LO))
			pc_next = {pc_hold_reg, alu_result};
		else if (skip_hit)
			pc_next = pc_inc + {{(PC_W-1){1'b0}}, 1'b1};
		else begin
			pc_next = pc_inc;
			take_two = 1'b0;
		end
	end

	// Execution pipeline on the quarter-cycle phase counter
	always @(posedge clock or negedge rst_b) begin
		if (!rst_b) begin
			phase_reg <= 2'h0;
			ir_reg <= 14'h0000;
			fdata_reg <= 8'h00;
			flush_reg <= 1'b0;
			prog_addr <= `RST_PC;
			wreg_reg <= 8'h00;
			status_reg <= `RST_STATUS;
			pc_hold_reg <= `RST_PC_HOLD;
			sp_reg <= {SP_W{1'b0}};
			port_out <= 8'h00;
			pin_dir <= `RST_DIR;
			global_interrupt_enable <= 1'b0;
			standby <= 1'b0;
			file_we <= 1'b0;
			file_waddr <= 7'h00;
			file_wdata <= 8'h00;
			prescaler_clear <= 1'b0;
			watchdog_clear <= 1'b0;
		end else begin
			file_we <= 1'b0;
			prescaler_clear <= 1'b0;
			watchdog_clear <= 1'b0;
			if (wake)
				standby <= 1'b0;
			phase_reg <= running ? phase_reg + 2'h1 : 2'h0;
			if (running && (phase_reg == 2'h1))
				ir_reg <= instr_data;
			if (running && (phase_reg == 2'h2))
				fdata_reg <= file_rdata;
			if (commit && flush_reg) begin
				flush_reg <= 1'b0;
			end else if (commit) begin
				flush_reg <= take_two;
				prog_addr <= pc_next;
				status_reg <= status_next;
				if (wr_w)
					wreg_reg <= alu_result;
				if (do_call) begin
					stack_mem[sp_reg] <= pc_inc;
					sp_reg <= sp_reg + {{(SP_W-1){1'b0}}, 1'b1};
				end
				if (do_ret)
					sp_reg <= sp_reg - {{(SP_W-1){1'b0}}, 1'b1};
				if (do_ret && use_lit)
					wreg_reg <= lit;
				if (do_int_ret)
					global_interrupt_enable <= 1'b1;
				if (do_sleep)
					standby <= 1'b1;
				watchdog_clear <= do_wd_clear;
				if (wr_f) begin
					case (faddr)
					`ADDR_PORT: port_out <= alu_result;
					`ADDR_DIR: pin_dir <= alu_result | `DIR_FORCED;
					`ADDR_PC_HOLD: pc_hold_reg <= alu_result[4:0];
					`ADDR_INTCON: global_interrupt_enable <= alu_result[`BIT_INT_EN];
					default: begin
						file_we <= ~is_internal(faddr);
						file_waddr <= faddr;
						file_wdata <= alu_result;
					end
					endcase
					prescaler_clear <= (faddr == `ADDR_TIMER) & prescaler_to_timer;
				end
			end
		end
	end

	// Pins pass three flops; a level counts once the last two agree
	always @(posedge clock or negedge rst_b) begin
		if (!rst_b) begin
			sync1_reg <= 8'h00;
			sync2_reg <= 8'h00;
			sync3_reg <= 8'h00;
			pins_reg <= 8'h00;
		end else begin
			sync1_reg <= pins_in;
			sync2_reg <= sync1_reg;
			sync3_reg <= sync2_reg;
			if (sync2_reg == sync3_reg)
				pins_reg <= sync3_reg;
		end
	end

	// AXI4-Lite slave; address and data may arrive in either order
	assign s_axi_awready = ~aw_held_reg & ~s_axi_bvalid;
	assign s_axi_wready = ~w_held_reg & ~s_axi_bvalid;
	assign s_axi_arready = ~s_axi_rvalid;

	always @(posedge clock or negedge rst_b) begin
		if (!rst_b) begin
			aw_held_reg <= 1'b0;
			w_held_reg <= 1'b0;
			awaddr_reg <= 8'h00;
			wdata_reg <= 32'h00000000;
			wstrb_reg <= 4'h0;
			s_axi_bvalid <= 1'b0;
			s_axi_bresp <= `RESP_OKAY;
			s_axi_rvalid <= 1'b0;
			s_axi_rresp <= `RESP_OKAY;
			s_axi_rdata <= 32'h00000000;
			run_reg <= `RST_RUN;
		end else begin
			if (s_axi_awvalid && s_axi_awready) begin
				aw_held_reg <= 1'b1;
				awaddr_reg <= s_axi_awaddr;
			end
			if (s_axi_wvalid && s_axi_wready) begin
				w_held_reg <= 1'b1;
				wdata_reg <= s_axi_wdata;
				wstrb_reg <= s_axi_wstrb;
			end
			if (aw_held_reg && w_held_reg && !s_axi_bvalid) begin
				aw_held_reg <= 1'b0;
				w_held_reg <= 1'b0;
				s_axi_bvalid <= 1'b1;
				s_axi_bresp <= `RESP_OKAY;
				case ({awaddr_reg[7:2], 2'b00})
				`AXI_CTRL: if (wstrb_reg[0]) run_reg <= wdata_reg[0];
				`AXI_STATE, `AXI_CORE, `AXI_INSTR: s_axi_bresp <= `RESP_OKAY;
				default: s_axi_bresp <= `RESP_SLVERR;
				endcase
			end else if (s_axi_bvalid && s_axi_bready)
				s_axi_bvalid <= 1'b0;
			if (s_axi_arvalid && s_axi_arready) begin
				s_axi_rvalid <= 1'b1;
				s_axi_rresp <= `RESP_OKAY;
				case ({s_axi_araddr[7:2], 2'b00})
				`AXI_CTRL: s_axi_rdata <= {31'h00000000, run_reg};
				`AXI_STATE: s_axi_rdata <= {9'h000, {(5-SP_W){1'b0}}, sp_reg, flush_reg,
					standby, {(16-PC_W){1'b0}}, prog_addr};
				`AXI_CORE: s_axi_rdata <= {8'h00, 3'h0, pc_hold_reg, status_reg, wreg_reg};
				`AXI_INSTR: s_axi_rdata <= {18'h00000, ir_reg};
				default: begin
					s_axi_rdata <= 32'h00000000;
					s_axi_rresp <= `RESP_SLVERR;
				end
				endcase
			end else if (s_axi_rvalid && s_axi_rready)
				s_axi_rvalid <= 1'b0;
		end
	end
endmodule
`default_nettype wire

// ### tb/risc_core_properties.sv
// Concurrent checks on the instruction core, bound to its top module.
// Assumes one clock domain and the asynchronous active-low reset.
`timescale 1ns/1ns
`default_nettype none
`include "risc_core_defines.vh"
module risc_core_properties #(
	parameter PC_W = 13
) (
	input wire logic clock, // Core clock
	input wire logic rst_b, // Reset, active low
	input wire logic s_axi_awvalid, // Write address valid
	input wire logic s_axi_awready, // Write address ready
	input wire logic s_axi_wvalid, // Write data valid
	input wire logic s_axi_wready, // Write data ready
	input wire logic [1:0] s_axi_bresp, // Write response
	input wire logic s_axi_bvalid, // Response valid
	input wire logic s_axi_bready, // Response ready
	input wire logic s_axi_arvalid, // Read address valid
	input wire logic s_axi_arready, // Read address ready
	input wire logic [31:0] s_axi_rdata, // Read data
	input wire logic s_axi_rvalid, // Read valid
	input wire logic s_axi_rready, // Read ready
	input wire logic [PC_W-1:0] prog_addr, // Fetch address
	input wire logic [6:0] file_waddr, // File write address
	input wire logic file_we, // File write pulse
	input wire logic [7:0] pin_dir, // Direction register
	input wire logic prescaler_to_timer, // Prescaler owner
	input wire logic prescaler_clear, // Prescaler clear pulse
	input wire logic watchdog_clear // Watchdog clear pulse
);
	default clocking @(posedge clock); endclocking
	default disable iff (!rst_b);
	a_presc_cause: assert property (prescaler_clear |-> file_we && file_waddr == `ADDR_TIMER)
		else $error("prescaler cleared without timer write");
	a_timer_clears: assert property (file_we && file_waddr == `ADDR_TIMER && prescaler_to_timer
		|-> prescaler_clear) else $error("timer write left prescaler");
	a_dir_bit3: assert property (pin_dir[3] == 1'b1)
		else $error("direction bit 3 low");
	a_we_pulse: assert property (file_we |=> !file_we[*3])
		else $error("file writes closer than one cycle");
	a_wd_pulse: assert property (watchdog_clear |=> !watchdog_clear[*3])
		else $error("watchdog pulse too long");
	a_pc_stands: assert property ($changed(prog_addr) |=> $stable(prog_addr)[*3])
		else $error("fetch address moved inside a cycle");
	a_b_hold: assert property (s_axi_bvalid && !s_axi_bready |=> s_axi_bvalid && $stable(s_axi_bresp))
		else $error("write response dropped");
	a_r_hold: assert property (s_axi_rvalid && !s_axi_rready |=> s_axi_rvalid && $stable(s_axi_rdata))
		else $error("read data dropped");
	a_ar_refused: assert property (s_axi_rvalid |-> !s_axi_arready)
		else $error("read taken while answering");
	a_rd_answer: assert property (s_axi_arvalid && s_axi_arready |=> s_axi_rvalid)
		else $error("read answer late");
	a_wr_answer: assert property (s_axi_awvalid && s_axi_awready && s_axi_wvalid && s_axi_wready
		|=> ##1 s_axi_bvalid) else $error("write answer late");
	c_presc: cover property (prescaler_clear);
	c_wd: cover property (watchdog_clear);
	c_we: cover property (file_we);
	c_bresp: cover property (s_axi_bvalid && s_axi_bresp == `RESP_SLVERR);
endmodule
bind risc_14bit_instruction_decode risc_core_properties #(.PC_W(PC_W)) props_i (.clock, .rst_b,
	.s_axi_awvalid, .s_axi_awready, .s_axi_wvalid, .s_axi_wready, .s_axi_bresp, .s_axi_bvalid,
	.s_axi_bready, .s_axi_arvalid, .s_axi_arready, .s_axi_rdata, .s_axi_rvalid, .s_axi_rready,
	.prog_addr, .file_waddr, .file_we, .pin_dir, .prescaler_to_timer, .prescaler_clear,
	.watchdog_clear);
`default_nettype wire

// ### tb/prog_file_model.sv
// Program memory and external file register space facing the core.
// Assumes the core samples fetch and read data late in its cycle.
`timescale 1ns/1ns
`default_nettype none
module prog_file_model #(
	parameter PC_W = 13
) (
	input wire logic clock, // Core clock
	input wire logic [PC_W-1:0] prog_addr, // Fetch address
	output logic [13:0] instr_data, // Fetched word
	input wire logic [6:0] file_addr, // Read address
	output logic [7:0] file_rdata, // Read data
	input wire logic [6:0] file_waddr, // Write address
	input wire logic [7:0] file_wdata, // Write data
	input wire logic file_we // Write pulse
);
	logic [13:0] rom [0:31];
	logic [7:0] ram [0:127];
	// Small program store; upper address bits alias
	assign instr_data = rom[prog_addr[4:0]];
	assign file_rdata = ram[file_addr];
	always @(posedge clock) begin
		if (file_we)
			ram[file_waddr] <= file_wdata;
	end
endmodule
`default_nettype wire

// ### tb/risc_14bit_instruction_decode_tb.sv
// Self-checking bench: runs a fixed program with random operands, then reads state.
// Assumes the checker binds itself and the model answers fetches at once.
`timescale 1ns/1ns
`default_nettype none
`include "risc_core_defines.vh"
module risc_14bit_instruction_decode_tb;
	logic clock, rst_b, s_axi_awvalid, s_axi_wvalid, s_axi_bready, s_axi_arvalid, s_axi_rready;
	logic s_axi_awready, s_axi_wready, s_axi_bvalid, s_axi_arready, s_axi_rvalid, file_we;
	logic prescaler_to_timer, prescaler_clear, watchdog_clear, standby, wake, saw_pc, saw_wd;
	logic global_interrupt_enable;
	logic [7:0] s_axi_awaddr, s_axi_araddr, file_wdata, file_rdata, pins_in, port_out, pin_dir;
	logic [7:0] a, r, q, p;
	logic [31:0] s_axi_wdata, s_axi_rdata, rd;
	logic [3:0] s_axi_wstrb;
	logic [1:0] s_axi_bresp, s_axi_rresp, resp;
	logic [12:0] prog_addr;
	logic [13:0] instr_data;
	logic [13:0] prog [0:16];
	logic [6:0] file_addr, file_waddr;
	logic [8:0] sum;
	int fails, n_checks, seed;
	risc_14bit_instruction_decode risc_14bit_instruction_decode_i (.clock, .rst_b, .s_axi_awaddr,
		.s_axi_awvalid, .s_axi_awready, .s_axi_wdata, .s_axi_wstrb, .s_axi_wvalid, .s_axi_wready,
		.s_axi_bresp, .s_axi_bvalid, .s_axi_bready, .s_axi_araddr, .s_axi_arvalid, .s_axi_arready,
		.s_axi_rdata, .s_axi_rresp, .s_axi_rvalid, .s_axi_rready, .prog_addr, .instr_data,
		.file_addr, .file_rdata, .file_waddr, .file_wdata, .file_we, .pins_in, .port_out, .pin_dir,
		.prescaler_to_timer, .prescaler_clear, .watchdog_clear, .standby, .wake,
		.global_interrupt_enable);
	prog_file_model prog_file_model_i (.clock, .prog_addr, .instr_data, .file_addr, .file_rdata,
		.file_waddr, .file_wdata, .file_we);
	always #4 clock = ~clock;
	always @(posedge clock) begin
		saw_pc <= rst_b && (saw_pc || prescaler_clear);
		saw_wd <= rst_b && (saw_wd || watchdog_clear);
	end
	function automatic logic [13:0] bop(input logic [3:0] op, input logic d, input logic [6:0] f);
		return {2'b00, op, d, f};
	endfunction
	function automatic logic [7:0] exp_status(input logic [7:0] pins);
		return 8'h18 | {5'h00, pins == 8'h00, 2'b00};
	endfunction
	function automatic logic [7:0] m(input logic [6:0] ad);
		return prog_file_model_i.ram[ad];
	endfunction
	task automatic check(input logic [31:0] seen, input logic [31:0] exp);
		n_checks++;
		if (seen !== exp) begin
			fails++;
			$display("BAD %0t seen %h expected %h", $time, seen, exp);
		end
	endtask
	task automatic results;
		if (fails == 0 && n_checks > 0)
			$display("Regression OK");
		else
			$display("Regression broken");
		$finish;
	endtask
	task automatic axi_write(input logic [7:0] ad, input logic [31:0] d, output logic [1:0] rs);
		@(posedge clock);
		s_axi_awaddr <= ad;
		s_axi_wdata <= d;
		s_axi_awvalid <= 1'b1;
		s_axi_wvalid <= 1'b1;
		s_axi_bready <= 1'b1;
		do begin
			@(posedge clock);
			if (s_axi_awready)
				s_axi_awvalid <= 1'b0;
			if (s_axi_wready)
				s_axi_wvalid <= 1'b0;
		end while (!s_axi_bvalid);
		rs = s_axi_bresp;
		s_axi_bready <= 1'b0;
	endtask
	task automatic axi_read(input logic [7:0] ad, output logic [31:0] d, output logic [1:0] rs);
		@(posedge clock);
		s_axi_araddr <= ad;
		s_axi_arvalid <= 1'b1;
		s_axi_rready <= 1'b1;
		do begin
			@(posedge clock);
			if (s_axi_arready)
				s_axi_arvalid <= 1'b0;
		end while (!s_axi_rvalid);
		d = s_axi_rdata;
		rs = s_axi_rresp;
		s_axi_rready <= 1'b0;
	endtask
	initial begin
		#100000;
		fails++;
		results();
	end
	initial begin
		seed = 32'h2c71;
		{clock, rst_b, s_axi_awvalid, s_axi_wvalid, s_axi_bready, s_axi_arvalid} = 6'h00;
		{s_axi_rready, prescaler_to_timer, wake, pins_in} = 11'h000;
		{s_axi_awaddr, s_axi_araddr, s_axi_wdata} = 48'h0;
		s_axi_wstrb = 4'hf;
		for (int it = 0; it < 4; it++) begin
			rst_b <= 1'b0;
			// First pass forces a carry out and an all-low port
			a = (it == 0) ? 8'hff : 8'($random(seed));
			r = (it == 0) ? 8'h01 : 8'($random(seed));
			q = 8'($random(seed));
			p = 8'($random(seed));
			pins_in <= (it == 0) ? 8'h00 : 8'($random(seed));
			prescaler_to_timer <= (it == 0) ? 1'b1 : 1'($random(seed));
			prog = '{{6'h30, a}, bop(4'h7, 1, 7'h20), bop(4'hd, 1, 7'h22), bop(4'h1, 1, 7'h03),
				bop(4'h8, 0, 7'h03), bop(4'h0, 1, 7'h31), bop(4'hb, 1, 7'h21), {6'h30, 8'hee},
				bop(4'h0, 1, 7'h32), bop(4'h1, 1, 7'h06), bop(4'h8, 1, 7'h05), bop(4'h0, 1, 7'h01),
				{4'b0101, 3'd7, 7'h23}, 14'h0064, {3'b100, 11'd16}, {3'b101, 11'd15}, {6'h34, 8'h5a}};
			for (int i = 0; i < 17; i++)
				prog_file_model_i.rom[i] = prog[i];
			// Stale results of the previous pass must not satisfy this one
			for (int i = 0; i < 128; i++)
				prog_file_model_i.ram[i] = 8'h00;
			prog_file_model_i.ram[7'h20] = r;
			prog_file_model_i.ram[7'h21] = 8'h01;
			prog_file_model_i.ram[7'h22] = q;
			prog_file_model_i.ram[7'h23] = p;
			repeat (4) @(posedge clock);
			rst_b <= 1'b1;
			axi_read(`AXI_CTRL, rd, resp);
			check(rd, 32'h1);
			while (prog_addr !== 13'd15)
				@(posedge clock);
			sum = {1'b0, r} + {1'b0, a};
			check(m(7'h20), sum[7:0]);
			check(m(7'h22), {q[6:0], sum[8]});
			check(m(7'h31), 8'h04);
			check(m(7'h21), 8'h00);
			check(m(7'h32), 8'h04);
			check(m(7'h01), 8'h04);
			check(saw_pc, prescaler_to_timer);
			check(m(7'h23), p | 8'h80);
			check(pin_dir, 8'h08);
			check(port_out, pins_in);
			check({standby, global_interrupt_enable, saw_wd}, 3'b001);
			axi_read(`AXI_CORE, rd, resp);
			check(rd[15:0], {exp_status(pins_in), 8'h5a});
			axi_read(`AXI_STATE, rd, resp);
			check(rd[12:0], 13'd15);
			axi_read(8'h10, rd, resp);
			check(resp, `RESP_SLVERR);
			axi_write(8'h14, 32'h0, resp);
			check(resp, `RESP_SLVERR);
			axi_write(`AXI_CTRL, 32'h0, resp);
			axi_read(`AXI_CTRL, rd, resp);
			check(rd, 32'h0);
		end
		results();
	end
endmodule
`default_nettype wire
